// file: include/ctk_pkg.sv
// Purpose : shared constants and carriers for the touch-key readout block
// Assumes : one 32-bit avalon word per 8-bit register, data in lane 0
// Notes   : module registers sit below the common ones in the byte map
package ctk_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NMOD    = 4;
  localparam int KEYS    = 4;
  localparam int CNT_W   = 16;
  localparam int TMR_W   = 8;
  localparam int MINOR_W = 5;
  localparam int TRIM_W  = 10;
  localparam int AW      = 8;
  localparam int DW      = 32;
  localparam int PAD_W   = DW - 8;

  // trim scale: capacitance is trim times full scale over steps
  localparam int TRIM_FULL_PF = 50;
  localparam int TRIM_STEPS   = 1024;

  // ************************************************************
  // address map: bit 7 picks common area, bits 6:5 module, 4:2 register
  // ************************************************************
  localparam logic [2:0] REG_CNT_LO   = 3'h0;
  localparam logic [2:0] REG_CNT_HI   = 3'h1;
  localparam logic [2:0] REG_TRIM_LO  = 3'h2;
  localparam logic [2:0] REG_TRIM_HI  = 3'h3;
  localparam logic [2:0] REG_FREQ_CTL = 3'h4;
  localparam logic [2:0] REG_OSC_PIN  = 3'h5;
  localparam logic [2:0] REG_COM_CTL  = 3'h0;
  localparam logic [2:0] REG_COM_RNG  = 3'h1;
  localparam logic [2:0] REG_COM_RLD  = 3'h2;
  localparam int         A_AREA       = 7;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int C0_MFREQ  = 5;
  localparam int C0_FILT   = 4;
  localparam int C0_HOP    = 3;
  localparam int C1_TSS    = 7;
  localparam int C1_ROEN   = 5;
  localparam int C1_KOEN   = 4;
  localparam int CC_RCOV   = 6;
  localparam int CC_START  = 5;
  localparam int CC_CFOV   = 4;
  localparam int CC_16OV   = 3;
  localparam int CC_SHARED_SLOT_COUNTER_SELECT   = 2;

  // ************************************************************
  // reset values and limits
  // ************************************************************
  localparam logic [1:0]         RANGE_RST = 2'h3;
  localparam logic [CNT_W-1:0]   CNT_MAX   = 16'hFFFF;
  localparam logic [TMR_W-1:0]   TMR_MAX   = 8'hFF;
  localparam logic [MINOR_W-1:0] MINOR_MAX = 5'h1F;

  typedef struct packed {
    logic [TRIM_W-1:0] trim;
    logic [7:0]        freq_ctl;
    logic [7:0]        osc_pin;
  } ctk_mod_cfg_t;

  typedef struct packed {
    logic       shared_slot_counter_select;
    logic [1:0] div;
    logic [1:0] range;
    logic [7:0] reload;
  } ctk_common_t;

endpackage : ctk_pkg

// file: logic/ctk_touch.sv
// Purpose : four capacitive touch-key counting modules behind avalon-mm
// Assumes : oscillator outputs arrive as asynchronous pins, slower than clk/4
// Notes   : results are latched at the end of each slot, on the same edge that clears the counters
`timescale 1ns/10ps
`default_nettype none
module ctk_touch
  import ctk_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  // avalon-mm slave
  input  wire logic [AW-1:0]           avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [DW-1:0]           avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [DW-1:0]           avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // oscillator pins
  input  wire logic [NMOD-1:0]         key_osc_i,
  input  wire logic [NMOD-1:0]         ref_osc_i,
  // oscillator and pad control
  output logic      [NMOD-1:0]         key_osc_enable_o,
  output logic      [NMOD-1:0]         ref_osc_enable_o,
  output logic      [NMOD*3-1:0]       osc_freq_select_o,
  output logic      [NMOD*TRIM_W-1:0]  ref_cap_trim_o,
  output logic      [NMOD-1:0]         multi_freq_enable_o,
  output logic      [NMOD-1:0]         filter_enable_o,
  output logic      [NMOD*2-1:0]       mux_key_select_o,
  output logic      [NMOD*KEYS-1:0]    key_pin_function_select_o,
  output logic      [1:0]              touch_osc_freq_range_o,
  // event
  output logic                         touch_irq_o
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_q1_r;
  logic rst_n;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n    <= rst_q1_r;
    end
  end

  // ************************************************************
  // bus slave: one wait state, read data stands with the answer
  // ************************************************************
  logic            ack_r;
  logic [DW-1:0]   rdata_r;
  logic [7:0]      rd_byte;
  wire             req       = avs_read_i | avs_write_i;
  wire             wr_stb    = avs_write_i & ack_r & avs_byteenable_i[0];
  wire             in_common = avs_address_i[A_AREA];
  wire [1:0]       a_mod     = avs_address_i[6:5];
  wire [2:0]       a_reg     = avs_address_i[4:2];
  wire [7:0]       wbyte     = avs_writedata_i[7:0];
  wire             wr_cc     = wr_stb & in_common & (a_reg == REG_COM_CTL);
  wire             wr_rng    = wr_stb & in_common & (a_reg == REG_COM_RNG);
  wire             wr_rld    = wr_stb & in_common & (a_reg == REG_COM_RLD);

  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read_i & ~ack_r) begin
        rdata_r <= {{PAD_W{1'b0}}, rd_byte};
      end
    end
  end

  // ************************************************************
  // common control and flags
  // ************************************************************
  ctk_common_t     com_r;
  logic            start_r;
  logic            start_d_r;
  logic            running_r;
  logic            rcov_r;
  logic            cfov_r;
  logic            ov16_r;
  logic            irq_r;
  logic [2:0]      pre_r;
  logic [NMOD-1:0] fc_ovf;
  logic [NMOD-1:0] c16_ovf;
  logic [NMOD-1:0] slot_ovf;
  logic [NMOD-1:0] sel_ovf;
  logic [NMOD-1:0] done_r;
  logic [NMOD-1:0] mod_en;
  logic            end_evt;

  wire start_rise = start_r & ~start_d_r;
  wire [NMOD-1:0] mod_en_eff = (mod_en == '0) ? NMOD'(1) : mod_en;
  // waiting for every enabled module keeps slow pads from being cut short
  wire all_done = &(done_r | sel_ovf | ~mod_en_eff);
  assign end_evt = running_r & (com_r.shared_slot_counter_select ? sel_ovf[0] : all_done);
  wire clr_cnt = ~start_r | end_evt;

  // prescaler for the divided system clock ticks
  wire [2:0] div_mask = (com_r.div == 2'h0) ? 3'h0 :
                        (com_r.div == 2'h1) ? 3'h1 :
                        (com_r.div == 2'h2) ? 3'h3 : 3'h7;
  wire div_tick  = (pre_r & div_mask) == 3'h0;
  wire sys4_tick = pre_r[1:0] == 2'h0;
  wire [7:0] cc_byte = {1'b0, rcov_r, start_r, cfov_r, ov16_r, com_r.shared_slot_counter_select, com_r.div};

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      com_r     <= '{shared_slot_counter_select: 1'b0, div: 2'h0, range: RANGE_RST, reload: 8'h00};
      start_r   <= 1'b0;
      start_d_r <= 1'b0;
      running_r <= 1'b0;
      rcov_r    <= 1'b0;
      cfov_r    <= 1'b0;
      ov16_r    <= 1'b0;
      irq_r     <= 1'b0;
      pre_r     <= 3'h0;
    end else begin
      pre_r     <= pre_r + 3'h1;
      start_d_r <= start_r;
      irq_r     <= end_evt;
      if (wr_cc) begin
        start_r    <= wbyte[CC_START];
        com_r.shared_slot_counter_select <= wbyte[CC_SHARED_SLOT_COUNTER_SELECT];
        com_r.div  <= wbyte[1:0];
      end
      if (wr_rng) begin
        com_r.range <= wbyte[1:0];
      end
      if (wr_rld) begin
        com_r.reload <= wbyte;
      end
      // software may only clear a flag; a set in the same cycle wins
      rcov_r <= end_evt | (rcov_r & ~(wr_cc & ~wbyte[CC_RCOV]));
      cfov_r <= (|fc_ovf) | (cfov_r & ~(wr_cc & ~wbyte[CC_CFOV]));
      ov16_r <= c16_ovf[0] | (ov16_r & ~(wr_cc & ~wbyte[CC_16OV]));
      if (end_evt | ~start_r) begin
        running_r <= 1'b0;
      end else if (start_rise) begin
        running_r <= 1'b1;
      end
    end
  end

  assign touch_irq_o            = irq_r;
  assign touch_osc_freq_range_o = com_r.range;

  // ************************************************************
  // oscillator pin synchronisers
  // ************************************************************
  logic [NMOD-1:0] ko_q1_r, ko_q2_r, ko_q3_r;
  logic [NMOD-1:0] ro_q1_r, ro_q2_r, ro_q3_r;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ko_q1_r <= '0;
      ko_q2_r <= '0;
      ko_q3_r <= '0;
      ro_q1_r <= '0;
      ro_q2_r <= '0;
      ro_q3_r <= '0;
    end else begin
      ko_q1_r <= key_osc_i;
      ko_q2_r <= ko_q1_r;
      ko_q3_r <= ko_q2_r;
      ro_q1_r <= ref_osc_i;
      ro_q2_r <= ro_q1_r;
      ro_q3_r <= ro_q2_r;
    end
  end
  wire [NMOD-1:0] key_edge = ko_q2_r & ~ko_q3_r;
  wire [NMOD-1:0] ref_edge = ro_q2_r & ~ro_q3_r;

  // ************************************************************
  // per-module counting, four identical copies
  // ************************************************************
  ctk_mod_cfg_t       cfg_r    [NMOD];
  logic [CNT_W-1:0]   fc_r     [NMOD];
  logic [CNT_W-1:0]   c16_r    [NMOD];
  logic [CNT_W-1:0]   result_r [NMOD];
  logic [TMR_W-1:0]   tmr_r    [NMOD];
  logic [MINOR_W-1:0] minor_r  [NMOD];
  logic [2:0]         hop_r    [NMOD];

  for (genvar m = 0; m < NMOD; m++) begin : g_mod
    wire       wr_m     = wr_stb & ~in_common & (a_mod == 2'(m));
    wire       run_m    = running_r & ~done_r[m];
    wire       hop_m    = cfg_r[m].freq_ctl[C0_HOP];
    wire       slot_tk  = cfg_r[m].osc_pin[C1_TSS] ? sys4_tick : ref_edge[m];
    wire       slot_st  = run_m & slot_tk;
    wire       tmr_wrap = slot_st & (tmr_r[m] == TMR_MAX);
    wire       fc_inc   = run_m & cfg_r[m].osc_pin[C1_KOEN] & key_edge[m];
    wire       c16_inc  = run_m & div_tick;

    assign slot_ovf[m] = tmr_wrap & (minor_r[m] == MINOR_MAX);
    assign sel_ovf[m]  = com_r.shared_slot_counter_select ? slot_ovf[0] : slot_ovf[m];
    assign fc_ovf[m]   = fc_inc & (fc_r[m] == CNT_MAX);
    assign c16_ovf[m]  = c16_inc & (c16_r[m] == CNT_MAX);
    assign mod_en[m]   = |cfg_r[m].osc_pin[KEYS-1:0];

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        cfg_r[m] <= '0;
      end else if (wr_m) begin
        case (a_reg)
          REG_TRIM_LO:  cfg_r[m].trim[7:0]         <= wbyte;
          REG_TRIM_HI:  cfg_r[m].trim[TRIM_W-1:8]  <= wbyte[1:0];
          REG_FREQ_CTL: cfg_r[m].freq_ctl          <= wbyte;
          REG_OSC_PIN:  cfg_r[m].osc_pin           <= {wbyte[7], 1'b0, wbyte[5:0]};
          default:      cfg_r[m]                   <= cfg_r[m];
        endcase
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        fc_r[m]     <= '0;
        c16_r[m]    <= '0;
        result_r[m] <= '0;
        tmr_r[m]    <= '0;
        minor_r[m]  <= '0;
        hop_r[m]    <= '0;
        done_r[m]   <= 1'b0;
      end else begin
        if (start_rise & hop_m) begin
          hop_r[m] <= hop_r[m] + 3'h1;
        end
        if (end_evt) begin
          result_r[m] <= fc_r[m];
          tmr_r[m]    <= com_r.reload;
        end else if (wr_rld & ~running_r) begin
          tmr_r[m] <= wbyte;
        end else if (slot_st) begin
          tmr_r[m] <= tmr_wrap ? com_r.reload : tmr_r[m] + 8'h01;
        end
        if (clr_cnt) begin
          fc_r[m]    <= '0;
          c16_r[m]   <= '0;
          minor_r[m] <= '0;
          done_r[m]  <= 1'b0;
        end else begin
          if (fc_inc) begin
            fc_r[m] <= fc_r[m] + 16'h0001;
          end
          if (c16_inc) begin
            c16_r[m] <= c16_r[m] + 16'h0001;
          end
          if (tmr_wrap) begin
            minor_r[m] <= minor_r[m] + 5'h01;
          end
          done_r[m] <= done_r[m] | sel_ovf[m];
        end
      end
    end

    // enables follow the run state so a finished slot silences the pads
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        key_osc_enable_o[m] <= 1'b0;
        ref_osc_enable_o[m] <= 1'b0;
      end else begin
        key_osc_enable_o[m] <= run_m & cfg_r[m].osc_pin[C1_KOEN];
        ref_osc_enable_o[m] <= run_m & cfg_r[m].osc_pin[C1_ROEN];
      end
    end

    assign osc_freq_select_o[m*3 +: 3] = hop_m ? hop_r[m] : cfg_r[m].freq_ctl[2:0];
    assign ref_cap_trim_o[m*TRIM_W +: TRIM_W] = cfg_r[m].trim;
    assign multi_freq_enable_o[m] = cfg_r[m].freq_ctl[C0_MFREQ];
    assign filter_enable_o[m]     = cfg_r[m].freq_ctl[C0_FILT];
    assign mux_key_select_o[m*2 +: 2] = cfg_r[m].freq_ctl[7:6];
    assign key_pin_function_select_o[m*KEYS +: KEYS] = cfg_r[m].osc_pin[KEYS-1:0];
  end

  // ************************************************************
  // read decode; unmapped words read zero
  // ************************************************************
  wire [7:0] mod_byte =
    (a_reg == REG_CNT_LO)   ? result_r[a_mod][7:0] :
    (a_reg == REG_CNT_HI)   ? result_r[a_mod][15:8] :
    (a_reg == REG_TRIM_LO)  ? cfg_r[a_mod].trim[7:0] :
    (a_reg == REG_TRIM_HI)  ? {6'h00, cfg_r[a_mod].trim[TRIM_W-1:8]} :
    (a_reg == REG_FREQ_CTL) ? cfg_r[a_mod].freq_ctl :
    (a_reg == REG_OSC_PIN)  ? cfg_r[a_mod].osc_pin : 8'h00;
  wire [7:0] com_byte =
    (a_reg == REG_COM_CTL)  ? cc_byte :
    (a_reg == REG_COM_RNG)  ? {6'h00, com_r.range} :
    (a_reg == REG_COM_RLD)  ? com_r.reload : 8'h00;
  assign rd_byte = in_common ? com_byte : mod_byte;

  // ************************************************************
  // checks
  // ************************************************************
  a_start_runs: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    start_rise |=> running_r)
    else $error("start edge did not switch counting on");
  a_stop_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !start_r |=> (fc_r[0] == 16'h0000) && (c16_r[0] == 16'h0000) && (minor_r[0] == 5'h00))
    else $error("counters not cleared while start is low");
  a_end_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    end_evt |=> !running_r && (tmr_r[1] == $past(com_r.reload)) && (fc_r[1] == 16'h0000))
    else $error("end of slot did not clear counters");
  a_osc_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    end_evt |-> ##2 (key_osc_enable_o == '0) && (ref_osc_enable_o == '0))
    else $error("oscillators still enabled after slot overflow");
  a_irq_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    end_evt |=> touch_irq_o && rcov_r ##1 !touch_irq_o)
    else $error("touch interrupt not a single pulse with flag");
  a_result_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    end_evt |=> result_r[0] == $past(fc_r[0]))
    else $error("result not latched at end of slot");
  a_cfov_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (|fc_ovf) || (cfov_r && !wr_cc) |=> cfov_r)
    else $error("sense overflow flag lost");
  a_ov16_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    c16_ovf[0] |=> ov16_r && (c16_r[0] == 16'h0000 || $past(clr_cnt)))
    else $error("module 0 counter overflow not flagged");
  a_hop_ignore: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    cfg_r[0].freq_ctl[C0_HOP] && $past(cfg_r[0].freq_ctl[C0_HOP]) && !$past(start_rise)
    && $changed(cfg_r[0].freq_ctl[2:0]) |-> $stable(osc_freq_select_o[2:0]))
    else $error("frequency field leaked through while hopping");
  a_slot_interval: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    g_mod[0].slot_st && (tmr_r[0] == TMR_MAX) && (minor_r[0] != MINOR_MAX) && !clr_cnt
    |=> (tmr_r[0] == $past(com_r.reload)) && (minor_r[0] == $past(minor_r[0]) + 5'h01))
    else $error("timer wrap did not reload and step the slot count");
  a_wait_once: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    req && !ack_r |=> !avs_waitrequest_o)
    else $error("bus answer not given after one wait state");

endmodule : ctk_touch
`default_nettype wire

// file: sim/ctk_pad_model.sv
// Purpose : touch pads seen as free oscillators, one key and one reference per module
// Assumes : pads stop and rest low whenever their enable is low
// Notes   : periods unrelated to clk_sys_i so the synchroniser is exercised
`timescale 1ns/10ps
`default_nettype none
module ctk_pad_model #(
  parameter int KEY_HALF_NS = 230,
  parameter int REF_HALF_NS = 310
) (
  // enables from the block
  input  wire logic [3:0] key_en_i,
  input  wire logic [3:0] ref_en_i,
  // oscillator outputs
  output var  logic [3:0] key_osc_o,
  output var  logic [3:0] ref_osc_o
);
  // ************************************************************
  // oscillators
  // ************************************************************
  for (genvar g = 0; g < 4; g++) begin : g_pad
    logic k;
    logic r;
    initial begin
      k = 1'b0;
      forever begin
        #(KEY_HALF_NS + g * 7);
        k = key_en_i[g] ? ~k : 1'b0;
      end
    end
    initial begin
      r = 1'b0;
      forever begin
        #(REF_HALF_NS + g * 5);
        r = ref_en_i[g] ? ~r : 1'b0;
      end
    end
    assign key_osc_o[g] = k;
    assign ref_osc_o[g] = r;
  end
endmodule : ctk_pad_model
`default_nettype wire

// file: sim/ctk_touch_test.sv
// Purpose : self-checking bench for the touch-key block over avalon-mm
// Assumes : one wait state per access, slot clock sys/4 for exact timing
// Notes   : oscillator counts are checked within a window, phase is free
`timescale 1ns/10ps
`default_nettype none
module ctk_touch_test;
  import ctk_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [AW-1:0] adr = '0;
  logic [DW-1:0] wdat = '0, rdat;
  logic [3:0] be = 4'hF, kosc, rosc, koen, roen, mfe, fle;
  logic [11:0] fsel;
  logic [39:0] trim;
  logic [7:0] mux;
  logic [15:0] kpin;
  logic [1:0] rng;
  logic waitreq, irq;
  int failures = 0, n_compared = 0;
  ctk_touch ctk_touch_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .key_osc_i(kosc), .ref_osc_i(rosc),
    .key_osc_enable_o(koen), .ref_osc_enable_o(roen), .osc_freq_select_o(fsel),
    .ref_cap_trim_o(trim), .multi_freq_enable_o(mfe), .filter_enable_o(fle),
    .mux_key_select_o(mux), .key_pin_function_select_o(kpin),
    .touch_osc_freq_range_o(rng), .touch_irq_o(irq));
  ctk_pad_model ctk_pad_model_inst (.key_en_i(koen), .ref_en_i(roen), .key_osc_o(kosc),
    .ref_osc_o(rosc));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge clk_sys_i);
    adr <= a;
    wdat <= {24'h0, d};
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_i);
      if (waitreq === 1'b0) break;
    end
    if (k == 50) check("bus answer", 32'h0, 32'h1);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    // the write lands at the answer edge; let it settle before pins are looked at
    @(posedge clk_sys_i);
  endtask : wreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(nm, q, exp);
  endtask : rchk
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 6; r++) rchk("reset value", 8'(m * 32 + r * 4), 32'h0);
    end
    rchk("range reset", 8'h84, 32'h3);
    check("range pin", {30'h0, rng}, 32'h3);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_regs;
    for (int m = 0; m < 4; m++) begin
      wreg(8'(m * 32 + 8), 8'(8'hA5 + m));
      wreg(8'(m * 32 + 12), 8'hFF);
      rchk("trim high", 8'(m * 32 + 12), 32'h3);
      check("trim pin", {22'h0, trim[m*10+:10]}, {22'h0, 2'h3, 8'(8'hA5 + m)});
      wreg(8'(m * 32 + 16), 8'(8'h70 + m));
      check("mfreq", {31'h0, mfe[m]}, 32'h1);
      check("filter", {31'h0, fle[m]}, 32'h1);
      check("mux", {30'h0, mux[m*2+:2]}, 32'h1);
      check("freq field", {29'h0, fsel[m*3+:3]}, 32'(m));
      wreg(8'(m * 32 + 20), 8'(8'h41 << m));
      rchk("pin ctl", 8'(m * 32 + 20), 32'(8'(8'h41 << m) & 8'hBF));
      check("key pins", {16'h0, kpin}, 32'(16'h1 << (m * 5)));
      wreg(8'(m * 32 + 20), 8'h00);
      wreg(8'(m * 32 + 0), 8'h55);
      rchk("count ro", 8'(m * 32), 32'h0);
    end
    for (int c = 0; c < 8; c++) begin
      wreg(8'h30, 8'(c));
      check("freq code", {29'h0, fsel[5:3]}, 32'(c));
    end
    wreg(8'h10, 8'h0F);
    check("hop on", {29'h0, fsel[2:0]}, 32'h0);
    wreg(8'h10, 8'h0B);
    check("hop field", {29'h0, fsel[2:0]}, 32'h0);
    wreg(8'h90, 8'hFF);
    rchk("unmapped", 8'h90, 32'h0);
    wreg(8'h84, 8'h00);
    rchk("range write", 8'h84, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_slot(input logic [7:0] rld, input int lo, input int hi, input logic ts,
                        input int hop);
    int k;
    int slot = (256 - rld) * 32 * 4;
    logic [31:0] cl, ch;
    wreg(8'h14, 8'hB0);
    wreg(8'h88, rld);
    wreg(8'h80, 8'h00);
    wreg(8'h80, {5'h04, ts, 2'h0});
    for (k = 0; k < slot + 40; k++) begin
      @(posedge clk_sys_i);
      if (irq === 1'b1) break;
      if (k == 8) check("osc enables", {24'h0, koen, roen}, 32'h11);
    end
    check("slot length ok", 32'(k + 3 >= slot && k <= slot), 32'h1);
    check("hop code", {29'h0, fsel[2:0]}, 32'(hop));
    repeat (3) @(posedge clk_sys_i);
    check("enables stop", {24'h0, koen, roen}, 32'h0);
    rchk("slot flag", 8'h80, {24'h0, 5'h0C, ts, 2'h0});
    bus(1'b0, 8'h00, 8'h00, cl);
    bus(1'b0, 8'h04, 8'h00, ch);
    k = int'({ch[7:0], cl[7:0]});
    check("sense count ok", 32'(k >= lo && k <= hi), 32'h1);
    wreg(8'h80, 8'h00);
    rchk("flag cleared", 8'h80, 32'h0);
    $display("t_slot done");
  endtask : t_slot
  // ************************************************************
  // verdict and main flow
  // ************************************************************
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    #4000000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_reset();
    t_regs();
    t_slot(8'hFE, 20, 40, 1'b0, 1);
    t_slot(8'hFF, 8, 20, 1'b1, 2);
    complete_run();
  end
endmodule : ctk_touch_test
`default_nettype wire
